// ==== verilog/slr_defines.svh ====
/*
  Constants of the serial LCD refresh driver: frame layout, register map,
  reset values and refresh timing.
  Assumes it is included by bare name wherever these names are used.
*/
`ifndef SLR_DEFINES_SVH
`define SLR_DEFINES_SVH

`define SLR_FRAME_BITS 5'h1E
`define SLR_HDR_BITS 5'h05
`define SLR_HDR_LAST 5'h04
`define SLR_ROWS 8
`define SLR_COLS 25
`define SLR_COL_MSB 24
`define SLR_ENTRY_W 31
`define SLR_FIFO_DEPTH 16
`define SLR_ROW_MIN_M1 3'h1

`define SLR_ADDR_CTRL 8'h00
`define SLR_ADDR_DIV 8'h04
`define SLR_ADDR_STATUS 8'h08
`define SLR_ADDR_RAMSEL 8'h0C
`define SLR_ADDR_RAMDATA 8'h10

`define SLR_CTRL_HOLD 0
`define SLR_STAT_OVF 4
`define SLR_DIV_RST 16'h00C8
`define SLR_ROWS_M1_RST 3'h7
`define SLR_ZERO32 32'h0000_0000

`endif

// ==== verilog/slr_pkg.sv ====
/*
  Types of the serial LCD refresh driver: frame phases and mode codes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package slr_pkg;
  typedef enum logic [1:0] {
    SLR_FR_IDLE = 2'b00,
    SLR_FR_HEAD = 2'b01,
    SLR_FR_COLS = 2'b11,
    SLR_FR_OVER = 2'b10
  } slr_frame_t;

  typedef enum logic [1:0] {
    SLR_MODE_WRITE = 2'b00,
    SLR_MODE_READ = 2'b01,
    SLR_MODE_INIT_BLANK = 2'b10,
    SLR_MODE_INIT_SHOW = 2'b11
  } slr_mode_t;
endpackage

// ==== verilog/slr_fifo.sv ====
/*
  Flip-flop FIFO with valid/ready on both sides and a fill level.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module slr_fifo #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [AW:0] level_out
);
  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  wire push = in_valid_in & in_ready_out;
  wire pop = out_valid_out & out_ready_in;

  assign level_out = wr_ptr_reg - rd_ptr_reg;
  assign in_ready_out = (level_out != (AW+1)'(DEPTH));
  assign out_valid_out = (level_out != '0);
  assign out_data_out = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  // Storage needs no reset; nothing is read before it is written
  always_ff @(posedge clk_in) begin
    if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
  end
endmodule

// ==== verilog/slr_top.sv ====
/*
  Serial command front end, display RAM and refresh scanner of an
  8 x 25 multiplexed LCD driver, with an APB register slave.
  Assumes the serial pins are asynchronous to SYS_CLK_IN and slow
  against it, and that an APB master drives the register port.
*/
// What this block does
// - Frame is row, mode, then 25 column bits
// - Row field binary, first bit is MSB
// - Row field is address or rows minus one
// - Mode bits select write, read, two inits
// - Write stores position 6..30 as column 1..25
// - Blank init blanks display, takes row count
// - Blank init with columns also writes row
// - Visible init sets count and shows display
// - Visible init may stop; else reads row out
// - Row count programmable from 2 to 8
// - 8 x 25 RAM refreshed without host
// - Serial bits move on serial clock falls
// - Serial bits taken only while chip select low
// - Read shifts column 25 down to 1
// - One bit lights pixel, zero leaves dark
`timescale 1ns/1ps
`include "slr_defines.svh"
module slr_top (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic APB_PSEL_IN,
  input wire logic APB_PENABLE_IN,
  input wire logic APB_PWRITE_IN,
  input wire logic [7:0] APB_PADDR_IN,
  input wire logic [31:0] APB_PWDATA_IN,
  output logic [31:0] APB_PRDATA_OUT,
  output logic APB_PREADY_OUT,
  output logic APB_PSLVERR_OUT,
  input wire logic SER_CLK_IN,
  input wire logic SER_DATA_IN,
  input wire logic SER_CS_N_IN,
  output logic SER_DATA_OUT,
  output logic SER_DATA_OE_OUT,
  output logic [7:0] ROW_DRIVE_OUT,
  output logic [24:0] COL_DRIVE_OUT
);
  function automatic logic [24:0] rev25(input logic [24:0] v);
    logic [24:0] r;
    r = '0;
    for (int i = 0; i < `SLR_COLS; i++) r[i] = v[`SLR_COL_MSB-i];
    return r;
  endfunction

  function automatic logic [7:0] onehot8(input logic [2:0] idx);
    logic [7:0] r;
    r = '0;
    r[idx] = 1'b1;
    return r;
  endfunction

  // Serial pin synchronisers; stage 1 feeds stage 2 only
  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic sdi_s1_reg, sdi_s2_reg;
  logic csn_s1_reg, csn_s2_reg, csn_s3_reg;
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= 3'h7;
      {sdi_s1_reg, sdi_s2_reg} <= 2'h0;
      {csn_s1_reg, csn_s2_reg, csn_s3_reg} <= 3'h7;
    end else begin
      {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= {SER_CLK_IN, sclk_s1_reg, sclk_s2_reg};
      {sdi_s1_reg, sdi_s2_reg} <= {SER_DATA_IN, sdi_s1_reg};
      {csn_s1_reg, csn_s2_reg, csn_s3_reg} <= {SER_CS_N_IN, csn_s1_reg, csn_s2_reg};
    end
  end

  wire cs_act = ~csn_s2_reg;
  // Frames act at chip-select rise, so a cut frame never half-writes a row
  wire cs_rise = csn_s2_reg & ~csn_s3_reg;
  wire ser_fall = sclk_s3_reg & ~sclk_s2_reg & cs_act;

  // Frame assembly
  slr_pkg::slr_frame_t frame_reg, frame_next;
  logic [4:0] bit_cnt_reg;
  logic [29:0] shift_reg;
  logic [4:0] hdr_reg;
  wire take_bit = ser_fall & (frame_reg != slr_pkg::SLR_FR_OVER);
  wire [4:0] hdr_now = {shift_reg[3:0], sdi_s2_reg};
  wire hdr_done = take_bit & (bit_cnt_reg == `SLR_HDR_LAST);
  wire [2:0] hdr_row = hdr_reg[4:2];
  wire [1:0] hdr_mode = hdr_reg[1:0];
  wire frame_full = (frame_reg == slr_pkg::SLR_FR_OVER);
  wire [24:0] frame_cols = rev25(shift_reg[24:0]);

  always_comb begin
    frame_next = frame_reg;
    case (frame_reg)
      slr_pkg::SLR_FR_IDLE: begin
        if (take_bit) frame_next = slr_pkg::SLR_FR_HEAD;
      end
      slr_pkg::SLR_FR_HEAD: begin
        if (hdr_done) frame_next = slr_pkg::SLR_FR_COLS;
      end
      slr_pkg::SLR_FR_COLS: begin
        if (take_bit && bit_cnt_reg == `SLR_FRAME_BITS - 5'h01) begin
          frame_next = slr_pkg::SLR_FR_OVER;
        end
      end
      slr_pkg::SLR_FR_OVER: frame_next = slr_pkg::SLR_FR_OVER;
      default: frame_next = slr_pkg::SLR_FR_IDLE;
    endcase
    // Chip select high ends any frame, wherever it stands
    if (!cs_act) frame_next = slr_pkg::SLR_FR_IDLE;
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      frame_reg <= slr_pkg::SLR_FR_IDLE;
      bit_cnt_reg <= 5'h00;
      shift_reg <= 30'h0000_0000;
      hdr_reg <= 5'h00;
    end else begin
      frame_reg <= frame_next;
      if (!cs_act) begin
        bit_cnt_reg <= 5'h00;
      end else if (take_bit) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        shift_reg <= {shift_reg[28:0], sdi_s2_reg};
      end
      if (hdr_done) hdr_reg <= hdr_now;
    end
  end

  // Command queue between the serial side and the RAM
  logic [24:0] ram_reg [0:`SLR_ROWS-1];
  logic hold_reg;
  logic [30:0] q_out;
  logic q_valid, q_ready;
  logic [4:0] q_level;
  wire push_ok = (frame_reg == slr_pkg::SLR_FR_COLS) | frame_full;
  wire push_req = cs_rise & push_ok & (hdr_mode != slr_pkg::SLR_MODE_READ)
                  & ((hdr_mode != slr_pkg::SLR_MODE_WRITE) | frame_full);
  wire [30:0] push_word = {frame_full, hdr_reg, frame_cols};
  wire pop = q_valid & ~hold_reg;

  slr_fifo #(.WIDTH(`SLR_ENTRY_W), .DEPTH(`SLR_FIFO_DEPTH)) u_fifo (
    .clk_in(SYS_CLK_IN),
    .rst_in(RESET_IN),
    .in_valid_in(push_req),
    .in_ready_out(q_ready),
    .in_data_in(push_word),
    .out_valid_out(q_valid),
    .out_ready_in(~hold_reg),
    .out_data_out(q_out),
    .level_out(q_level)
  );

  wire q_full = q_out[30];
  wire [2:0] q_row = q_out[29:27];
  wire [1:0] q_mode = q_out[26:25];
  wire [24:0] q_cols = q_out[24:0];
  wire q_write = (q_mode == slr_pkg::SLR_MODE_WRITE)
                 | ((q_mode == slr_pkg::SLR_MODE_INIT_BLANK) & q_full);
  wire q_init = q_mode[1];
  // Fewer than two backplanes is raised to two
  wire [2:0] q_rows_m1 = (q_row < `SLR_ROW_MIN_M1) ? `SLR_ROW_MIN_M1 : q_row;

  logic [2:0] rows_m1_reg;
  logic visible_reg;
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      for (int i = 0; i < `SLR_ROWS; i++) ram_reg[i] <= 25'h000_0000;
      rows_m1_reg <= `SLR_ROWS_M1_RST;
      visible_reg <= 1'b0;
    end else if (pop) begin
      if (q_write) ram_reg[q_row] <= q_cols;
      if (q_init) begin
        rows_m1_reg <= q_rows_m1;
        visible_reg <= q_mode[0];
      end
    end
  end

  // Serial read-out: column 25 first, one column per fall
  logic [24:0] rd_sh_reg;
  logic rd_act_reg;
  logic sdo_reg, sdo_oe_reg;
  wire rd_start = hdr_done & sdi_s2_reg;
  // Reads bypass the queue; software lets it drain before reading
  wire [24:0] rd_word = ram_reg[hdr_now[4:2]];
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rd_sh_reg <= 25'h000_0000;
      rd_act_reg <= 1'b0;
      sdo_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else begin
      // Enable follows chip select, so a cut read frees the line
      sdo_oe_reg <= cs_act & (rd_act_reg | rd_start);
      if (!cs_act) begin
        rd_act_reg <= 1'b0;
      end else if (rd_start) begin
        rd_act_reg <= 1'b1;
        rd_sh_reg <= rd_word;
        sdo_reg <= rd_word[`SLR_COL_MSB];
      end else if (rd_act_reg && ser_fall) begin
        rd_sh_reg <= {rd_sh_reg[23:0], 1'b0};
        sdo_reg <= rd_sh_reg[23];
      end
    end
  end

  // Refresh scanner; the divider stands in for the internal oscillator
  logic [15:0] div_reg;
  logic [15:0] div_cnt_reg;
  logic [2:0] scan_reg;
  logic [7:0] row_drv_reg;
  logic [24:0] col_drv_reg;
  // Compare, not equality, so lowering DIV never strands the counter
  wire step = (div_cnt_reg >= div_reg);
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      div_cnt_reg <= 16'h0000;
      scan_reg <= 3'h0;
      row_drv_reg <= 8'h00;
      col_drv_reg <= 25'h000_0000;
    end else begin
      div_cnt_reg <= step ? 16'h0000 : div_cnt_reg + 16'h0001;
      if (step) scan_reg <= (scan_reg >= rows_m1_reg) ? 3'h0 : scan_reg + 3'h1;
      row_drv_reg <= visible_reg ? onehot8(scan_reg) : 8'h00;
      col_drv_reg <= visible_reg ? ram_reg[scan_reg] : 25'h000_0000;
    end
  end

  // APB slave, one wait state on every access
  logic ovf_reg;
  logic [2:0] ram_sel_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  wire apb_acc = APB_PSEL_IN & APB_PENABLE_IN;
  wire apb_wr = apb_acc & pready_reg & APB_PWRITE_IN;
  wire sel_ctrl = (APB_PADDR_IN == `SLR_ADDR_CTRL);
  wire sel_div = (APB_PADDR_IN == `SLR_ADDR_DIV);
  wire sel_stat = (APB_PADDR_IN == `SLR_ADDR_STATUS);
  wire sel_rsel = (APB_PADDR_IN == `SLR_ADDR_RAMSEL);
  wire sel_rdat = (APB_PADDR_IN == `SLR_ADDR_RAMDATA);
  wire mapped = sel_ctrl | sel_div | sel_stat | sel_rsel | sel_rdat;
  wire [31:0] stat_word = {19'h0_0000, scan_reg, q_level, ovf_reg, visible_reg, rows_m1_reg};
  wire [31:0] rd_mux = sel_ctrl ? {31'h0000_0000, hold_reg} :
                       sel_div ? {16'h0000, div_reg} :
                       sel_stat ? stat_word :
                       sel_rsel ? {29'h0000_0000, ram_sel_reg} :
                       sel_rdat ? {7'h00, ram_reg[ram_sel_reg]} : `SLR_ZERO32;
  // A full queue drops the frame; the sticky flag tells software
  wire ovf_set = push_req & ~q_ready;
  wire ovf_clr = apb_wr & sel_stat & APB_PWDATA_IN[`SLR_STAT_OVF];

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= `SLR_ZERO32;
    end else begin
      pready_reg <= apb_acc & ~pready_reg;
      pslverr_reg <= apb_acc & ~pready_reg & ~mapped;
      prdata_reg <= (apb_acc & ~pready_reg & ~APB_PWRITE_IN) ? rd_mux : `SLR_ZERO32;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      hold_reg <= 1'b0;
      div_reg <= `SLR_DIV_RST;
      ram_sel_reg <= 3'h0;
      ovf_reg <= 1'b0;
    end else begin
      if (apb_wr && sel_ctrl) hold_reg <= APB_PWDATA_IN[`SLR_CTRL_HOLD];
      if (apb_wr && sel_div) div_reg <= APB_PWDATA_IN[15:0];
      if (apb_wr && sel_rsel) ram_sel_reg <= APB_PWDATA_IN[2:0];
      ovf_reg <= ovf_set | (ovf_reg & ~ovf_clr);
    end
  end

  assign APB_PRDATA_OUT = prdata_reg;
  assign APB_PREADY_OUT = pready_reg;
  assign APB_PSLVERR_OUT = pslverr_reg;
  assign SER_DATA_OUT = sdo_reg;
  assign SER_DATA_OE_OUT = sdo_oe_reg;
  assign ROW_DRIVE_OUT = row_drv_reg;
  assign COL_DRIVE_OUT = col_drv_reg;

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_read_start;
    hdr_done && sdi_s2_reg && cs_act;
  endsequence

  sequence s_pop_mode(logic [1:0] m);
    pop && q_mode == m;
  endsequence

  a_header_take: assert property (hdr_done |=> hdr_reg == $past(hdr_now))
    else $error("header not captured at fifth bit");
  a_row_msb_first: assert property (hdr_done |=> hdr_row == $past(shift_reg[3:1]))
    else $error("row field bit order wrong");
  a_write_lands: assert property (s_pop_mode(slr_pkg::SLR_MODE_WRITE)
      |=> ram_reg[$past(q_row)] == $past(q_cols))
    else $error("write frame not stored");
  a_blank_init: assert property (s_pop_mode(slr_pkg::SLR_MODE_INIT_BLANK)
      |=> !visible_reg && rows_m1_reg == $past(q_rows_m1))
    else $error("blank init not applied");
  a_show_init: assert property (s_pop_mode(slr_pkg::SLR_MODE_INIT_SHOW)
      |=> visible_reg && rows_m1_reg == $past(q_rows_m1))
    else $error("visible init not applied");
  a_read_first_col: assert property (s_read_start
      |=> sdo_reg == $past(rd_word[24]) ##1 sdo_oe_reg)
    else $error("read-out does not begin at column 25");
  a_rows_range: assert property (rows_m1_reg >= `SLR_ROW_MIN_M1)
    else $error("row count below two");
  a_blank_dark: assert property (!visible_reg [*2]
      |-> row_drv_reg == 8'h00 && col_drv_reg == 25'h000_0000)
    else $error("pixels driven while blanked");
  a_cs_gate: assert property (!cs_act |=> !sdo_oe_reg && bit_cnt_reg == 5'h00)
    else $error("activity with chip select high");
  a_fall_only: assert property (cs_act && !ser_fall |=> $stable(bit_cnt_reg))
    else $error("bit counted without a clock fall");

  // Read-out, frame limit, scan and init checks
  a_read_shift: assert property (rd_act_reg && ser_fall && !rd_start
      |=> sdo_reg == $past(rd_sh_reg[23]))
    else $error("read-out did not step to the next column");
  a_oe_in_read: assert property (rd_act_reg && cs_act |=> sdo_oe_reg)
    else $error("data out not driven during read-out");
  a_cut_read: assert property (!cs_act |=> !rd_act_reg)
    else $error("read-out kept running with chip select high");
  a_frame_stops: assert property (frame_full |=> $stable(shift_reg))
    else $error("bit taken beyond the end of the frame");
  a_scan_wrap: assert property (step && scan_reg >= rows_m1_reg |=> scan_reg == 3'h0)
    else $error("scan passed the last used row");
  a_scan_drive: assert property (visible_reg
      |=> row_drv_reg == onehot8($past(scan_reg))
      && col_drv_reg == $past(ram_reg[scan_reg]))
    else $error("scanned row not driven from RAM");
  a_row_clamp: assert property (pop && q_init && q_row < `SLR_ROW_MIN_M1
      |=> rows_m1_reg == `SLR_ROW_MIN_M1)
    else $error("row count of one not raised to two");
  a_blank_short: assert property (pop && !q_full
      && q_mode == slr_pkg::SLR_MODE_INIT_BLANK
      |=> ram_reg[$past(q_row)] == $past(ram_reg[q_row]))
    else $error("short blank init wrote the RAM");
endmodule

// ==== testbench/slr_host_model.sv ====
/*
  Host model: shifts serial frames into the driver and collects read-out bits.
  Assumes clk_in is the driver's system clock; one serial clock period is
  16 of its cycles (80 ns at 5 ns), and the serial clock idles high.
*/
`timescale 1ns/1ps
module slr_host_model (
  input wire logic clk_in,
  input wire logic data_from_dev_in,
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic ser_cs_n_out
);
  logic drv_bit;
  logic idle_bit;
  // Data is not held while deselected; toggling exposes sampling outside frames
  assign ser_data_out = ser_cs_n_out ? idle_bit : drv_bit;
  initial begin
    ser_clk_out = 1'b1;
    ser_cs_n_out = 1'b1;
    drv_bit = 1'b0;
    idle_bit = 1'b0;
  end
  always @(posedge clk_in) begin
    idle_bit <= ~idle_bit;
  end
  task automatic send(input logic [29:0] frame, input int nbits, output logic [24:0] rd);
    rd = 25'h000_0000;
    ser_cs_n_out <= 1'b0;
    repeat (8) @(posedge clk_in);
    for (int i = 1; i <= nbits; i++) begin
      drv_bit <= frame[30 - i];
      repeat (8) @(posedge clk_in);
      ser_clk_out <= 1'b0;
      repeat (8) @(posedge clk_in);
      // Sampled just before the rise, eight cycles after the fall, where the output has long settled
      if (i >= 5 && i <= 29) begin
        rd[29 - i] = data_from_dev_in;
      end
      ser_clk_out <= 1'b1;
    end
    repeat (8) @(posedge clk_in);
    ser_cs_n_out <= 1'b1;
    repeat (10) @(posedge clk_in);
  endtask
endmodule

// ==== testbench/tb_serial_lcd_refresh_driver_control.sv ====
/*
  Self-checking bench of the serial LCD refresh driver: APB master tasks,
  a table of row writes, then refusal, init, queue-overflow and reset cases.
  Assumes the host model drives the serial pins and DIV is shortened to 2.
*/
`timescale 1ns/1ps
`include "slr_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_serial_lcd_refresh_driver_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sclk;
  logic sdin;
  logic scs_n;
  logic sdout;
  logic soe;
  logic [7:0] row_drv;
  logic [24:0] col_drv;
  int n_fail = 0;
  int checks = 0;
  logic [24:0] ram [8] = '{25'h1ff_ffff, 25'h000_0001, 25'h100_0000, 25'h0aa_aaaa,
                           25'h155_5555, 25'h012_3456, 25'h0f0_f0f0, 25'h000_0000};
  logic [31:0] v;
  logic e;
  logic [24:0] rd;
  logic [7:0] seen;
  always #2.5 clk = ~clk;
  slr_top i_slr_top (.SYS_CLK_IN(clk), .RESET_IN(rst), .APB_PSEL_IN(psel),
    .APB_PENABLE_IN(penable), .APB_PWRITE_IN(pwrite), .APB_PADDR_IN(paddr),
    .APB_PWDATA_IN(pwdata), .APB_PRDATA_OUT(prdata), .APB_PREADY_OUT(pready),
    .APB_PSLVERR_OUT(pslverr), .SER_CLK_IN(sclk), .SER_DATA_IN(sdin),
    .SER_CS_N_IN(scs_n), .SER_DATA_OUT(sdout), .SER_DATA_OE_OUT(soe),
    .ROW_DRIVE_OUT(row_drv), .COL_DRIVE_OUT(col_drv));
  slr_host_model i_slr_host_model (.clk_in(clk), .data_from_dev_in(sdout),
    .ser_clk_out(sclk), .ser_data_out(sdin), .ser_cs_n_out(scs_n));
  task automatic conclude();
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic err);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      conclude();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [24:0] rev(input logic [24:0] c);
    for (int i = 0; i < 25; i++) begin
      rev[i] = c[24 - i];
    end
  endfunction
  task automatic frame(input logic [2:0] r, input logic [1:0] m, input logic [24:0] c,
                       input int n);
    i_slr_host_model.send({r, m, rev(c)}, n, rd);
  endtask
  task automatic drain();
    int k;
    k = 0;
    do begin
      apb(1'b0, `SLR_ADDR_STATUS, 32'h0000_0000, v, e);
      k++;
    end while (v[9:5] !== 5'h00 && k < 50);
    if (k >= 50) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic ram_chk(input logic [2:0] r, input logic [24:0] c);
    apb(1'b1, `SLR_ADDR_RAMSEL, {29'h0, r}, v, e);
    apb(1'b0, `SLR_ADDR_RAMDATA, 32'h0000_0000, v, e);
    `CHK(v, {7'h00, c})
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK({row_drv, col_drv, soe}, 34'h0)
    apb(1'b0, `SLR_ADDR_STATUS, 32'h0000_0000, v, e);
    `CHK(v[9:0], 10'h007)
    apb(1'b0, `SLR_ADDR_DIV, 32'h0000_0000, v, e);
    `CHK(v, 32'h0000_00c8)
    apb(1'b0, 8'h20, 32'h0000_0000, v, e);
    `CHK({e, v}, 33'h1_0000_0000)
    apb(1'b1, `SLR_ADDR_DIV, 32'h0000_0002, v, e);
    for (int r = 0; r < 8; r++) begin
      frame(r[2:0], slr_pkg::SLR_MODE_WRITE, ram[r], 30);
      drain();
      ram_chk(r[2:0], ram[r]);
      frame(r[2:0], slr_pkg::SLR_MODE_READ, 25'h000_0000, 30);
      `CHK(rd, ram[r])
    end
    frame(3'h0, slr_pkg::SLR_MODE_WRITE, 25'h0c3_3c3c, 20);
    drain();
    ram_chk(3'h0, ram[0]);
    ram[3] = 25'h0ab_cdef;
    frame(3'h3, slr_pkg::SLR_MODE_INIT_BLANK, ram[3], 30);
    drain();
    ram_chk(3'h3, ram[3]);
    apb(1'b0, `SLR_ADDR_STATUS, 32'h0000_0000, v, e);
    `CHK(v[2:0], 3'h3)
    `CHK(v[3:0], 4'h3)
    repeat (40) @(posedge clk);
    `CHK({row_drv, col_drv}, 33'h0)
    frame(3'h3, slr_pkg::SLR_MODE_INIT_SHOW, 25'h000_0000, 30);
    `CHK(rd, ram[3])
    drain();
    `CHK(v[3:0], 4'hb)
    seen = 8'h00;
    for (int t = 0; t < 120; t++) begin
      @(posedge clk);
      for (int r = 0; r < 8; r++) begin
        if (row_drv === (8'h01 << r)) begin
          seen[r] = 1'b1;
          `CHK(col_drv, ram[r])
        end
      end
    end
    `CHK(seen, 8'h0f)
    frame(3'h0, slr_pkg::SLR_MODE_INIT_SHOW, 25'h000_0000, 5);
    drain();
    `CHK(v[3:0], 4'h9)
    // Queue stalled by HOLD so it fills until a frame is refused
    apb(1'b1, `SLR_ADDR_CTRL, 32'h0000_0001, v, e);
    repeat (17) frame(3'h7, slr_pkg::SLR_MODE_INIT_BLANK, 25'h000_0000, 5);
    apb(1'b0, `SLR_ADDR_STATUS, 32'h0000_0000, v, e);
    `CHK(v[9:3], 7'h43)
    apb(1'b1, `SLR_ADDR_CTRL, 32'h0000_0000, v, e);
    drain();
    `CHK(v[4:0], 5'h17)
    repeat (4) @(posedge clk);
    `CHK({row_drv, col_drv}, 33'h0)
    apb(1'b1, `SLR_ADDR_STATUS, 32'h0000_0010, v, e);
    apb(1'b0, `SLR_ADDR_STATUS, 32'h0000_0000, v, e);
    `CHK(v[4], 1'b0)
    // Reset in mid-run must restore the blanked power-up state
    frame(3'h1, slr_pkg::SLR_MODE_INIT_SHOW, 25'h000_0000, 5);
    drain();
    `CHK(v[3:0], 4'h9)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({row_drv, col_drv, soe}, 34'h0)
    apb(1'b0, `SLR_ADDR_STATUS, 32'h0000_0000, v, e);
    `CHK(v[9:0], 10'h007)
    apb(1'b0, `SLR_ADDR_DIV, 32'h0000_0000, v, e);
    `CHK(v, 32'h0000_00c8)
    conclude();
  end
endmodule
